/* sbc_defs.svh */
// Notes on behaviour
// RULE_01: error-report sync low time from 4-bit field; zero is half a cycle, plus one per step.
// RULE_02: sync-request low time from 4-bit field; zero is 5 frames plus 9 octets.
// RULE_03: report global multiframe clock period in parallel-clock cycles, 8-bit read-only.
// RULE_04: one enable bit per lane; a cleared bit keeps that lane's checker frozen.
// RULE_05: 3-bit lane selector picks which lane's error count is readable.
// RULE_06: 2-bit pattern selector picks the PRBS sequence; code 01 is PRBS15.
// RULE_07: checking runs while the run bit is 1 and stops while it is 0.
// RULE_08: clear bit at 1 resets the test state machine and all lane error counters.
// RULE_09: writable 24-bit error threshold in three byte registers, low to high.
// RULE_10: selected lane's 24-bit error count readable as three bytes, low to high.
// RULE_11: per-lane pass flags, 8-bit read-only, all pass after reset.
// RULE_12: enabled and running lanes count PRBS mismatches; fail once count exceeds threshold.
// RULE_13: far end sends the chosen PRBS sequence continuously on every lane under test.
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SBC_ADDR_SYNC_DUR 12'h312
`define SBC_ADDR_LMFC 12'h313
`define SBC_ADDR_LANE_EN 12'h315
`define SBC_ADDR_CTRL 12'h316
`define SBC_ADDR_THR_LO 12'h317
`define SBC_ADDR_THR_MID 12'h318
`define SBC_ADDR_THR_HI 12'h319
`define SBC_ADDR_CNT_LO 12'h31A
`define SBC_ADDR_CNT_MID 12'h31B
`define SBC_ADDR_CNT_HI 12'h31C
`define SBC_ADDR_PASS 12'h31D

// ----------------------------------------
// reset values
// ----------------------------------------
`define SBC_RST_BYTE 8'h00
`define SBC_RST_PASS 8'hFF
`define SBC_CTRL_WMASK 8'h7F

// ----------------------------------------
// timing figures
// ----------------------------------------
// half a cycle for a zero error-report setting rounds up to one cycle
`define SBC_ERR_BASE_CYC 12'h001
`define SBC_REQ_FRAMES 12'h005
`define SBC_REQ_OCTETS 12'h009
`define SBC_OCTETS_PER_CYC_LOG2 2
`define SBC_ROUND_UP_OCTETS 12'h003
`define SBC_LMFC_FIRST 8'h01
`define SBC_LMFC_MAX 8'hFF

// ----------------------------------------
// prbs taps, bit 0 of a word is first in time
// ----------------------------------------
`define SBC_TAP_P7_A 7
`define SBC_TAP_P7_B 6
`define SBC_TAP_P15_A 15
`define SBC_TAP_P15_B 14
`define SBC_TAP_P23_A 23
`define SBC_TAP_P23_B 18
`define SBC_TAP_P31_A 31
`define SBC_TAP_P31_B 28

`endif

/* sbc_lane_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.svh"

module sbc_lane_checker #(
  parameter int WORD_W = 32,
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lane_checker_enable,
  input wire logic checker_clear,
  input wire logic prime,
  input wire logic check,
  input wire sbc_pkg::sbc_pattern_t pattern_select,
  input wire logic [CNT_W-1:0] threshold,
  input wire logic [WORD_W-1:0] rx_word,
  output logic [CNT_W-1:0] error_count,
  output logic lane_pass
);

  // ----------------------------------------
  // pattern taps
  // ----------------------------------------
  function automatic int tap_a(input sbc_pkg::sbc_pattern_t p);
    unique case (p)
      sbc_pkg::SBC_PRBS7: tap_a = `SBC_TAP_P7_A;
      sbc_pkg::SBC_PRBS15: tap_a = `SBC_TAP_P15_A;
      sbc_pkg::SBC_PRBS23: tap_a = `SBC_TAP_P23_A;
      sbc_pkg::SBC_PRBS31: tap_a = `SBC_TAP_P31_A;
    endcase
  endfunction : tap_a

  function automatic int tap_b(input sbc_pkg::sbc_pattern_t p);
    unique case (p)
      sbc_pkg::SBC_PRBS7: tap_b = `SBC_TAP_P7_B;
      sbc_pkg::SBC_PRBS15: tap_b = `SBC_TAP_P15_B;
      sbc_pkg::SBC_PRBS23: tap_b = `SBC_TAP_P23_B;
      sbc_pkg::SBC_PRBS31: tap_b = `SBC_TAP_P31_B;
    endcase
  endfunction : tap_b

  logic [WORD_W-1:0] prev_word;
  logic [2*WORD_W-1:0] history;
  logic [WORD_W-1:0] mismatch;
  logic [CNT_W:0] next_error_count;
  logic [$clog2(WORD_W+1)-1:0] word_errors;
  logic active;

  assign active = lane_checker_enable && check; // RULE_04 RULE_07
  assign history = {rx_word, prev_word};

  // ----------------------------------------
  // self-synchronising compare
  // ----------------------------------------
  // a single line error shows as three mismatches; that is the price of
  // needing no seed lock and recovering by itself after a slip
  always_comb begin
    int ta;
    int tb;
    ta = tap_a(pattern_select);
    tb = tap_b(pattern_select);
    for (int i = 0; i < WORD_W; i++) begin
      mismatch[i] = history[WORD_W+i] ^ history[WORD_W+i-ta] ^ history[WORD_W+i-tb]; // RULE_06
    end
  end

  // count ones of the mismatch word
  always_comb begin
    word_errors = '0;
    for (int i = 0; i < WORD_W; i++) begin
      word_errors = word_errors + {{($bits(word_errors)-1){1'b0}}, mismatch[i]};
    end
    next_error_count = {1'b0, error_count} + {{(CNT_W+1-$bits(word_errors)){1'b0}}, word_errors};
  end

  // history word; a frozen lane keeps its last word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_word <= '0;
    end else if (checker_clear) begin
      prev_word <= '0;
    end else if (lane_checker_enable && (prime || check)) begin
      prev_word <= rx_word;
    end
  end

  // saturating error counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_count <= '0;
    end else if (checker_clear) begin
      error_count <= '0; // RULE_08
    end else if (active) begin
      error_count <= next_error_count[CNT_W] ? '1 : next_error_count[CNT_W-1:0]; // RULE_12
    end
  end

  // pass flag drops once the count is above threshold and stays down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_pass <= 1'b1; // RULE_11
    end else if (checker_clear) begin
      lane_pass <= 1'b1;
    end else if (active && (error_count > threshold)) begin
      lane_pass <= 1'b0; // RULE_12
    end
  end

endmodule : sbc_lane_checker
`default_nettype wire

/* sbc_pkg.sv */
package sbc_pkg;

  // pattern codes; only 01 is fixed, the others are this block's choice
  typedef enum logic [1:0] {
    SBC_PRBS7 = 2'h0,
    SBC_PRBS15 = 2'h1,
    SBC_PRBS23 = 2'h2,
    SBC_PRBS31 = 2'h3
  } sbc_pattern_t;

  // sync pulse durations register layout
  typedef struct packed {
    logic [3:0] error_report_low_time;
    logic [3:0] sync_request_low_time;
  } sbc_sync_dur_t;

  // test control register layout
  typedef struct packed {
    logic reserved;
    logic [2:0] error_count_lane_select;
    sbc_pattern_t pattern_select;
    logic checker_run;
    logic checker_clear;
  } sbc_ctrl_t;

  // test sequencer
  typedef enum logic [2:0] {
    SBC_IDLE = 3'h1,
    SBC_PRIME = 3'h2,
    SBC_CHECK = 3'h4
  } sbc_state_t;

  // register access request
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sbc_reg_req_t;

endpackage : sbc_pkg

/* sbc_prbs_tx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.svh"

module sbc_prbs_tx (
  input wire logic clk,
  input wire logic rst_n,
  input wire sbc_pkg::sbc_pattern_t pattern_select,
  input wire logic [7:0] flip_lanes,
  output logic [7:0][31:0] lane_data
);
  int tap_a[4] = '{`SBC_TAP_P7_A, `SBC_TAP_P15_A, `SBC_TAP_P23_A, `SBC_TAP_P31_A};
  int tap_b[4] = '{`SBC_TAP_P7_B, `SBC_TAP_P15_B, `SBC_TAP_P23_B, `SBC_TAP_P31_B};
  logic [30:0] hist;

  // free-running generator; flips touch only the line, so one flip is one bit error
  always @(negedge clk or negedge rst_n) begin : gen_words
    logic [30:0] h;
    logic [31:0] word;
    logic nb;
    if (!rst_n) begin
      hist = 31'h7FFFFFFF;
      lane_data = '0;
    end else begin
      h = hist;
      for (int i = 0; i < 32; i++) begin
        nb = h[tap_a[pattern_select] - 1] ^ h[tap_b[pattern_select] - 1];
        h = {h[29:0], nb};
        word[i] = nb;
      end
      hist = h;
      for (int l = 0; l < 8; l++) begin
        lane_data[l] = word ^ {31'h0, flip_lanes[l]};
      end
    end
  end
endmodule : sbc_prbs_tx
`default_nettype wire

/* sbc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.svh"

module sbc_top #(
  parameter int LANES = 8,
  parameter int WORD_W = 32,
  parameter int CNT_W = 24,
  parameter int SEL_W = 3,
  parameter int DUR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sbc_pkg::sbc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [LANES-1:0][WORD_W-1:0] lane_data,
  input wire logic [7:0] frame_octets,
  input wire logic sync_request_pulse,
  input wire logic error_report_pulse,
  input wire logic lmfc_pulse,
  output logic sync_output_n
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  sbc_pkg::sbc_sync_dur_t sync_pulse_durations;
  logic [LANES-1:0] ber_lane_enables;
  sbc_pkg::sbc_ctrl_t ber_test_control;
  logic [7:0] ber_threshold_low;
  logic [7:0] ber_threshold_mid;
  logic [7:0] ber_threshold_high;
  logic [7:0] multiframe_period_report;

  logic [CNT_W-1:0] threshold;
  logic [LANES-1:0][CNT_W-1:0] lane_counts;
  logic [LANES-1:0] lane_pass_flags;
  logic [CNT_W-1:0] selected_count;

  sbc_pkg::sbc_state_t state;
  sbc_pkg::sbc_state_t next_state;
  logic seq_prime;
  logic seq_check;
  logic [SEL_W-1:0] count_lane;

  // write decode used by every writable register
  function automatic logic wr_hit(input sbc_pkg::sbc_reg_req_t r, input logic [11:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // sync pulse durations
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_pulse_durations <= `SBC_RST_BYTE;
    end else if (wr_hit(reg_req, `SBC_ADDR_SYNC_DUR)) begin
      sync_pulse_durations <= reg_req.wdata;
    end
  end

  // lane enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ber_lane_enables <= LANES'(`SBC_RST_BYTE);
    end else if (wr_hit(reg_req, `SBC_ADDR_LANE_EN)) begin
      ber_lane_enables <= reg_req.wdata[LANES-1:0]; // RULE_04
    end
  end

  // test control; reserved top bit stays zero
  // clear is a level: software sets it and clears it again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ber_test_control <= `SBC_RST_BYTE;
    end else if (wr_hit(reg_req, `SBC_ADDR_CTRL)) begin
      ber_test_control <= reg_req.wdata & `SBC_CTRL_WMASK;
    end
  end

  // threshold low byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ber_threshold_low <= `SBC_RST_BYTE;
    end else if (wr_hit(reg_req, `SBC_ADDR_THR_LO)) begin
      ber_threshold_low <= reg_req.wdata; // RULE_09
    end
  end

  // threshold middle byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ber_threshold_mid <= `SBC_RST_BYTE;
    end else if (wr_hit(reg_req, `SBC_ADDR_THR_MID)) begin
      ber_threshold_mid <= reg_req.wdata; // RULE_09
    end
  end

  // threshold high byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ber_threshold_high <= `SBC_RST_BYTE;
    end else if (wr_hit(reg_req, `SBC_ADDR_THR_HI)) begin
      ber_threshold_high <= reg_req.wdata; // RULE_09
    end
  end

  // bytes are written one at a time, so a threshold change passes through
  // mixed values; software should stop the test while rewriting it
  assign threshold = {ber_threshold_high, ber_threshold_mid,
                      ber_threshold_low}; // RULE_09

  // ----------------------------------------
  // test sequencer
  // ----------------------------------------
  // prime loads one word of history so the first compare is not garbage;
  // stopping freezes counts and flags so they can be read at leisure
  always_comb begin
    next_state = state;
    unique case (state)
      sbc_pkg::SBC_IDLE: begin
        if (ber_test_control.checker_run) begin
          next_state = sbc_pkg::SBC_PRIME; // RULE_07
        end
      end
      sbc_pkg::SBC_PRIME: begin
        next_state = ber_test_control.checker_run ? sbc_pkg::SBC_CHECK : sbc_pkg::SBC_IDLE;
      end
      sbc_pkg::SBC_CHECK: begin
        if (!ber_test_control.checker_run) begin
          next_state = sbc_pkg::SBC_IDLE; // RULE_07
        end
      end
      default: next_state = sbc_pkg::SBC_IDLE;
    endcase
  end

  // clear holds the sequencer idle for as long as it is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sbc_pkg::SBC_IDLE;
    end else if (ber_test_control.checker_clear) begin
      state <= sbc_pkg::SBC_IDLE; // RULE_08
    end else begin
      state <= next_state;
    end
  end

  // one state decode shared by every lane
  // rather than a compare in each instance
  assign seq_prime = (state == sbc_pkg::SBC_PRIME);
  assign seq_check = (state == sbc_pkg::SBC_CHECK); // RULE_07

  // ----------------------------------------
  // lane checkers
  // ----------------------------------------
  // a lane enabled mid-run compares against stale history;
  // enable lanes before starting the test
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    sbc_lane_checker #(
      .WORD_W(WORD_W),
      .CNT_W(CNT_W)
    ) u_checker (
      .clk(clk),
      .rst_n(rst_n),
      .lane_checker_enable(ber_lane_enables[g]), // RULE_04
      .checker_clear(ber_test_control.checker_clear), // RULE_08
      .prime(seq_prime),
      .check(seq_check), // RULE_07
      .pattern_select(ber_test_control.pattern_select), // RULE_06
      .threshold(threshold), // RULE_09
      .rx_word(lane_data[g]),
      .error_count(lane_counts[g]),
      .lane_pass(lane_pass_flags[g])
    );
  end

  // count of the lane picked for readback; bytes are read live, so
  // stop the test before reading all three for a coherent value
  assign count_lane = SEL_W'(ber_test_control.error_count_lane_select); // RULE_05
  assign selected_count = lane_counts[count_lane]; // RULE_05

  // ----------------------------------------
  // multiframe clock period measurement
  // ----------------------------------------
  logic [7:0] lmfc_cycles;
  logic lmfc_seen;

  // cycles since the last pulse; saturates at the field width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_cycles <= `SBC_RST_BYTE;
    end else if (lmfc_pulse) begin
      lmfc_cycles <= `SBC_LMFC_FIRST;
    end else if (lmfc_cycles != `SBC_LMFC_MAX) begin
      lmfc_cycles <= lmfc_cycles + `SBC_LMFC_FIRST;
    end
  end

  // the first pulse only starts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_seen <= 1'b0;
    end else if (lmfc_pulse) begin
      lmfc_seen <= 1'b1;
    end
  end

  // a period is known only from the second pulse on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multiframe_period_report <= `SBC_RST_BYTE;
    end else if (lmfc_pulse && lmfc_seen) begin
      multiframe_period_report <= lmfc_cycles; // RULE_03
    end
  end

  // ----------------------------------------
  // sync output pulse generator
  // ----------------------------------------
  logic [DUR_W-1:0] low_left;
  logic [DUR_W-1:0] req_base_cycles;
  logic [DUR_W-1:0] req_cycles;
  logic [DUR_W-1:0] err_cycles;
  logic low_next;

  // five frames plus nine octets, rounded up to whole four-octet cycles
  assign req_base_cycles = DUR_W'((`SBC_REQ_FRAMES * {4'h0, frame_octets}
                           + `SBC_REQ_OCTETS + `SBC_ROUND_UP_OCTETS)
                           >> `SBC_OCTETS_PER_CYC_LOG2);
  assign req_cycles = req_base_cycles
                      + {8'h00, sync_pulse_durations.sync_request_low_time}; // RULE_02
  assign err_cycles = `SBC_ERR_BASE_CYC
                      + {8'h00, sync_pulse_durations.error_report_low_time}; // RULE_01

  // a request outranks an error report and restarts the low time
  // an error report during a low period is dropped, not queued
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_left <= '0;
    end else if (sync_request_pulse) begin
      low_left <= req_cycles; // RULE_02
    end else if (error_report_pulse && (low_left == '0)) begin
      low_left <= err_cycles; // RULE_01
    end else if (low_left != '0) begin
      low_left <= low_left - DUR_W'(1);
    end
  end

  // low while a period starts and on every counted cycle but the last
  assign low_next = sync_request_pulse || (error_report_pulse && (low_left == '0))
                    || (low_left > DUR_W'(1)); // RULE_01 RULE_02

  // registered so the pin never glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_output_n <= 1'b1;
    end else begin
      sync_output_n <= !low_next;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // answer strobe; reads never stall, so always one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd; // RULE_10
    end
  end

  // unmapped offsets read zero; data holds until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `SBC_RST_BYTE;
    end else begin
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          `SBC_ADDR_SYNC_DUR: reg_rdata <= sync_pulse_durations;
          `SBC_ADDR_LMFC: reg_rdata <= multiframe_period_report; // RULE_03
          `SBC_ADDR_LANE_EN: reg_rdata <= 8'(ber_lane_enables);
          `SBC_ADDR_CTRL: reg_rdata <= ber_test_control;
          `SBC_ADDR_THR_LO: reg_rdata <= ber_threshold_low;
          `SBC_ADDR_THR_MID: reg_rdata <= ber_threshold_mid;
          `SBC_ADDR_THR_HI: reg_rdata <= ber_threshold_high;
          `SBC_ADDR_CNT_LO: reg_rdata <= selected_count[7:0]; // RULE_10
          `SBC_ADDR_CNT_MID: reg_rdata <= selected_count[15:8]; // RULE_10
          `SBC_ADDR_CNT_HI: reg_rdata <= selected_count[23:16]; // RULE_10
          `SBC_ADDR_PASS: reg_rdata <= 8'(lane_pass_flags); // RULE_11
          default: reg_rdata <= `SBC_RST_BYTE;
        endcase
      end
    end
  end

endmodule : sbc_top
`default_nettype wire

/* sbc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.svh"

module sbc_top_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire sbc_pkg::sbc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] frame_octets,
  input wire logic sync_request_pulse,
  input wire logic error_report_pulse,
  input wire logic sync_output_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] dur_sh;
  logic [7:0] ctrl_sh;
  logic [11:0] low_cnt;
  logic [11:0] req_len;
  logic err_kind;
  logic rd_cnt;

  // --------------------------------
  // helper logic
  // --------------------------------
  // shadow of the sync duration register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dur_sh <= 8'h00;
    else if (reg_req.wr && reg_req.addr == `SBC_ADDR_SYNC_DUR) dur_sh <= reg_req.wdata;
  end
  // shadow of the control register, bit 7 never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl_sh <= 8'h00;
    else if (reg_req.wr && reg_req.addr == `SBC_ADDR_CTRL) ctrl_sh <= reg_req.wdata & 8'h7F;
  end
  // low cycles so far; a request restarts the period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 12'h000;
    else low_cnt <= (sync_output_n || sync_request_pulse) ? 12'h000 : low_cnt + 12'h001;
  end
  // kind of the running period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) err_kind <= 1'b0;
    else if (sync_request_pulse) err_kind <= 1'b0;
    else if (sync_output_n && error_report_pulse) err_kind <= 1'b1;
  end
  // request length: whole parallel cycles covering 5 frames plus 9 octets, plus the request low-time field
  assign req_len = ((12'(frame_octets) * 12'h005 + 12'h00C) >> 2) + 12'(dur_sh[3:0]);
  assign rd_cnt = reg_req.rd && reg_req.addr >= `SBC_ADDR_CNT_LO && reg_req.addr <= `SBC_ADDR_CNT_HI;

  sequence s_read(a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  sequence s_low3;
    !sync_output_n [*3];
  endsequence

  // --------------------------------
  // assertions
  // --------------------------------
  AST_RVALID_ON:
    assert property (reg_req.rd |=> reg_rvalid) else $error("read not answered");
  AST_RVALID_OFF:
    assert property (!reg_req.rd |=> !reg_rvalid) else $error("answer without read");
  AST_RDATA_HOLD:
    assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  AST_CTRL_READ:
    assert property (s_read(`SBC_ADDR_CTRL) |=> reg_rdata == $past(ctrl_sh))
    else $error("control readback wrong");
  AST_ERR_START:
    assert property (sync_output_n && error_report_pulse |=> !sync_output_n)
    else $error("error report did not pull sync low");
  AST_ERR_LEN:
    assert property ($rose(sync_output_n) && err_kind |-> low_cnt == 12'(dur_sh[7:4]) + 12'h001)
    else $error("error report low time wrong");
  AST_REQ_HOLD:
    assert property (sync_request_pulse |=> s_low3) else $error("request too short");
  AST_REQ_LEN:
    assert property ($rose(sync_output_n) && !err_kind |-> low_cnt == req_len)
    else $error("request low time wrong");
  AST_CLEAR_CNT:
    assert property (rd_cnt && ctrl_sh[0] && $past(ctrl_sh[0]) |=> reg_rdata == 8'h00)
    else $error("count not zero under clear");
  AST_CLEAR_PASS:
    assert property (s_read(`SBC_ADDR_PASS) ##0 (ctrl_sh[0] && $past(ctrl_sh[0]))
      |=> reg_rdata == 8'hFF) else $error("pass flags not set under clear");
endmodule : sbc_top_monitor

bind sbc_top sbc_top_monitor i_mon (
  .clk(clk),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .frame_octets(frame_octets),
  .sync_request_pulse(sync_request_pulse),
  .error_report_pulse(error_report_pulse),
  .sync_output_n(sync_output_n)
);
`default_nettype wire

/* test_serdes_prbs_ber_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module test_serdes_prbs_ber_checker;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sbc_pkg::sbc_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [7:0][31:0] lane_data;
  logic [7:0] frame_octets = 8'h04;
  logic sync_request_pulse = 1'b0;
  logic error_report_pulse = 1'b0;
  logic lmfc_pulse = 1'b0;
  logic sync_output_n;
  sbc_pkg::sbc_pattern_t tx_pattern = sbc_pkg::SBC_PRBS15;
  logic [7:0] flip_lanes = 8'h00;
  int fail_count = 0;
  int tests_run = 0;

  always #20 clk = ~clk;

  sbc_top i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .lane_data(lane_data),
    .frame_octets(frame_octets),
    .sync_request_pulse(sync_request_pulse),
    .error_report_pulse(error_report_pulse),
    .lmfc_pulse(lmfc_pulse),
    .sync_output_n(sync_output_n)
  );

  sbc_prbs_tx i_tx (
    .clk(clk),
    .rst_n(rst_n),
    .pattern_select(tx_pattern),
    .flip_lanes(flip_lanes),
    .lane_data(lane_data)
  );

  // --------------------------------
  // bus tasks
  // --------------------------------
  task automatic finish_test();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    reg_req.wr <= 1'b0;
  endtask : reg_write

  // answer is due exactly one cycle after the read edge
  task automatic expect_reg(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    reg_req.rd <= 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, exp)
  endtask : expect_reg

  // --------------------------------
  // scenarios
  // --------------------------------
  // reset values, then write and read back every offset
  task automatic t_regs();
    logic [11:0] a;
    logic [7:0] wd;
    logic [7:0] rv;
    logic [7:0] exp;
    for (int i = 'h312; i <= 'h31D; i++) begin
      a = 12'(i);
      wd = a[7:0] ^ 8'hC3;
      rv = (a == `SBC_ADDR_PASS) ? `SBC_RST_PASS : `SBC_RST_BYTE;
      exp = (a == 12'h312 || (a >= 12'h315 && a <= 12'h319)) ? wd : rv;
      if (a == `SBC_ADDR_CTRL) exp = wd & 8'h7F;
      expect_reg(a, rv);
      reg_write(a, wd);
      expect_reg(a, exp);
    end
    reg_write(`SBC_ADDR_CTRL, 8'h00);
  endtask : t_regs

  // boundary pulses twelve cycles apart
  task automatic t_lmfc();
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      lmfc_pulse <= 1'b1;
      @(negedge clk);
      lmfc_pulse <= 1'b0;
      repeat (10) @(negedge clk);
    end
    expect_reg(`SBC_ADDR_LMFC, 8'h0C);
  endtask : t_lmfc

  task automatic t_sync(input logic req, input logic [7:0] dur, input int n_exp);
    int n;
    reg_write(`SBC_ADDR_SYNC_DUR, dur);
    @(negedge clk);
    if (req) sync_request_pulse <= 1'b1;
    else error_report_pulse <= 1'b1;
    @(negedge clk);
    sync_request_pulse <= 1'b0;
    error_report_pulse <= 1'b0;
    n = 0;
    while (sync_output_n === 1'b0 && n < 64) begin
      n++;
      @(negedge clk);
    end
    if (n == 64) begin
      fail_count++;
      finish_test();
    end else begin
      `CHK(n, n_exp)
    end
  endtask : t_sync

  // lanes 1 and 5 take one bit error; lane 5 is disabled, lane 0 errs while stopped
  task automatic t_ber(input logic [1:0] pat, input logic [7:0] thr, input logic [7:0] pass);
    tx_pattern <= sbc_pkg::sbc_pattern_t'(pat);
    reg_write(`SBC_ADDR_CTRL, 8'h01);
    reg_write(`SBC_ADDR_THR_LO, thr);
    reg_write(`SBC_ADDR_THR_MID, 8'h00);
    reg_write(`SBC_ADDR_THR_HI, 8'h00);
    reg_write(`SBC_ADDR_LANE_EN, 8'h0F);
    reg_write(`SBC_ADDR_CTRL, {4'h0, pat, 2'b10});
    repeat (4) @(negedge clk);
    flip_lanes <= 8'h22;
    @(negedge clk);
    flip_lanes <= 8'h00;
    repeat (4) @(negedge clk);
    reg_write(`SBC_ADDR_CTRL, {4'h0, pat, 2'b00});
    flip_lanes <= 8'h01;
    @(negedge clk);
    flip_lanes <= 8'h00;
    repeat (3) @(negedge clk);
    for (int l = 0; l < 8; l++) begin
      reg_write(`SBC_ADDR_CTRL, {1'b0, 3'(l), pat, 2'b00});
      expect_reg(`SBC_ADDR_CNT_LO, (l == 1) ? 8'h03 : 8'h00);
    end
    expect_reg(`SBC_ADDR_PASS, pass);
    reg_write(`SBC_ADDR_CTRL, {4'h1, pat, 2'b01});
    @(negedge clk);
    expect_reg(`SBC_ADDR_PASS, 8'hFF);
    expect_reg(`SBC_ADDR_CNT_LO, 8'h00);
    reg_write(`SBC_ADDR_CTRL, 8'h00);
  endtask : t_ber

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_lmfc();
    t_sync(1'b0, 8'h00, 1);
    t_sync(1'b0, 8'h20, 3);
    t_sync(1'b1, 8'h01, 9);
    t_sync(1'b1, 8'h00, 8);
    t_ber(2'h0, 8'h03, 8'hFF);
    t_ber(2'h1, 8'h02, 8'hFD);
    t_ber(2'h2, 8'h03, 8'hFF);
    t_ber(2'h3, 8'h02, 8'hFD);
    finish_test();
  end
endmodule : test_serdes_prbs_ber_checker
`default_nettype wire
